//--- packed_float_codec.sv
// decoder and encoder between one unsigned packed float format and single float
`timescale 1ns/1ns
module packed_float_codec #(
  parameter int MW = 6
) (
  input  wire logic [MW+4:0] code_i,
  input  wire logic [31:0]   flt_i,
  output logic      [31:0]   dec_o,
  output logic      [MW+4:0] enc_o
);

  localparam int CW = MW + packed_float_norm_convert_pkg::PK_EXP_W;
  localparam int MAXC = (packed_float_norm_convert_pkg::PK_EXP_TOP << MW) | ((1 << MW) - 1);
  localparam int INFC = packed_float_norm_convert_pkg::PK_EXP_SPEC << MW;

  logic [4:0]    pk_exp;
  logic [MW-1:0] pk_mant;

  // exponent is code / 2^MW, mantissa is code mod 2^MW
  assign pk_exp  = code_i[CW-1:MW];
  assign pk_mant = code_i[MW-1:0];

  always_comb begin
    logic [4:0]  p;
    logic [31:0] sh;
    p     = packed_float_norm_convert_pkg::lead_one(32'(pk_mant));
    sh    = 32'(pk_mant) << (5'd23 - p);
    dec_o = packed_float_norm_convert_pkg::FLT_ZERO;
    if (pk_exp == 5'h00) begin
      if (pk_mant != '0) begin
        // denormal 2^-14 * M/2^MW, normal in single precision
        dec_o = {1'b0, 8'(32'(p) + 32'(packed_float_norm_convert_pkg::FLT_EXP_BIAS)
                 - 32'(MW) - 32'(packed_float_norm_convert_pkg::PK_DEN_SHIFT)),
                 sh[22:0]};
      end
    end else if (pk_exp == 5'(packed_float_norm_convert_pkg::PK_EXP_SPEC)) begin
      dec_o = (pk_mant == '0) ? packed_float_norm_convert_pkg::FLT_POS_INF
                              : packed_float_norm_convert_pkg::FLT_QNAN;
    end else begin
      dec_o = {1'b0, 8'(32'(pk_exp) + 32'(packed_float_norm_convert_pkg::FLT_EXP_BIAS)
               - 32'(packed_float_norm_convert_pkg::PK_EXP_BIAS)),
               pk_mant, (23 - MW)'(0)};
    end
  end

  always_comb begin
    logic        s;
    logic [7:0]  fe;
    logic [22:0] ff;
    logic [31:0] sig;
    int          u;
    int          shn;
    int          base;
    int          rnd;
    int          tot;
    s     = flt_i[31];
    fe    = flt_i[30:23];
    ff    = flt_i[22:0];
    sig   = {9'h001, ff};
    u     = int'(fe) - packed_float_norm_convert_pkg::FLT_EXP_BIAS;
    shn   = 0;
    base  = 0;
    rnd   = 0;
    tot   = 0;
    enc_o = '0;
    if (fe == 8'(packed_float_norm_convert_pkg::FLT_EXP_SPEC)) begin
      // nan of either sign to positive nan, -inf to zero, +inf kept
      if (ff != '0) begin
        enc_o = CW'(INFC | 1);
      end else if (!s) begin
        enc_o = CW'(INFC);
      end
    end else if (s || fe == 8'h00) begin
      // negatives become zero, denormal inputs flush to zero
      enc_o = '0;
    end else if (u > packed_float_norm_convert_pkg::PK_EXP_BIAS) begin
      enc_o = CW'(MAXC);
    end else begin
      if (u >= 1 - packed_float_norm_convert_pkg::PK_EXP_BIAS) begin
        base = ((u + packed_float_norm_convert_pkg::PK_EXP_BIAS) << MW) | int'(ff >> (23 - MW));
        rnd  = int'(ff[22-MW]);
      end else begin
        shn = 23 - MW + (1 - packed_float_norm_convert_pkg::PK_EXP_BIAS - u);
        if (shn < 31) begin
          base = int'(sig >> shn);
          rnd  = int'(sig[shn-1]);
        end
      end
      // round to nearest, a carry moves into the exponent field
      tot = base + rnd;
      enc_o = (tot > MAXC) ? CW'(MAXC) : CW'(tot);
    end
  end

endmodule : packed_float_codec

//--- packed_float_norm_convert.sv
// numeric conversion datapath: packed floats, 16.16 fixed and normalized integers
`timescale 1ns/1ns
module packed_float_norm_convert #(
  parameter int B = packed_float_norm_convert_pkg::NORM_B_DEF
) (
  input  wire logic                                clk_i,
  input  wire logic                                sys_rst_i,
  input  wire logic                                valid_i,
  input  wire packed_float_norm_convert_pkg::req_t req_i,
  output packed_float_norm_convert_pkg::rsp_t      rsp_o
);

  localparam logic [31:0] UMAX  = 32'((64'h1 << B) - 64'h1);
  localparam logic [31:0] SMAX  = 32'((64'h1 << (B - 1)) - 64'h1);
  localparam logic [31:0] BMASK = UMAX;

  logic [31:0] dec11;
  logic [31:0] dec10;
  logic [10:0] enc11;
  logic [9:0]  enc10;
  logic [31:0] result_d;
  logic [31:0] data_q;
  logic        valid_q;

  // magnitude * 2^-fb to single float, truncating below the mantissa
  function automatic logic [31:0] mag_to_flt(input logic sgn, input logic [31:0] mag,
                                              input int fb);
    logic [4:0]  p;
    logic [31:0] al;
    p  = packed_float_norm_convert_pkg::lead_one(mag);
    al = (p >= 5'd23) ? (mag >> (p - 5'd23)) : (mag << (5'd23 - p));
    if (mag == 32'h0) begin
      return packed_float_norm_convert_pkg::FLT_ZERO;
    end
    return {sgn, 8'(32'(p) + 32'(packed_float_norm_convert_pkg::FLT_EXP_BIAS) - 32'(fb)),
            al[22:0]};
  endfunction : mag_to_flt

  // c / (2^w - 1) below one is c repeated through the fraction
  function automatic logic [31:0] rep_frac(input logic [31:0] c, input int w);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < packed_float_norm_convert_pkg::NORM_FRAC_W; i++) begin
      r[31-i] = c[w - 1 - (i % w)];
    end
    return r;
  endfunction : rep_frac

  // round(f * (2^w - 1)) for a positive normal f below one
  function automatic logic [31:0] scale_norm(input logic [31:0] f, input int w);
    logic [63:0] fx;
    logic [63:0] r;
    int          sh;
    sh = packed_float_norm_convert_pkg::FLT_EXP_BIAS - int'(f[30:23]);
    fx = 64'h0;
    if (f[30:23] != 8'h00 && sh <= 40) begin
      fx = ({40'h0, 1'b1, f[22:0]} << 9) >> sh;
    end
    r = (fx << w) - fx + 64'h0000_0000_8000_0000;
    return r[63:32];
  endfunction : scale_norm

  packed_float_codec #(
    .MW (packed_float_norm_convert_pkg::UF11_MANT_W)
  ) u_codec11 (
    .code_i (req_i.data[10:0]),
    .flt_i  (req_i.data),
    .dec_o  (dec11),
    .enc_o  (enc11)
  );

  packed_float_codec #(
    .MW (packed_float_norm_convert_pkg::UF10_MANT_W)
  ) u_codec10 (
    .code_i (req_i.data[9:0]),
    .flt_i  (req_i.data),
    .dec_o  (dec10),
    .enc_o  (enc10)
  );

  always_comb begin
    logic        sgn;
    logic [31:0] cb;
    logic [31:0] mag;
    logic        is_nan;
    logic        ge_one;
    sgn      = req_i.data[31];
    cb       = req_i.data & BMASK;
    mag      = 32'h0;
    is_nan   = (req_i.data[30:23] == 8'hff) && (req_i.data[22:0] != 23'h0);
    ge_one   = req_i.data[30:23] >= 8'(packed_float_norm_convert_pkg::FLT_EXP_BIAS);
    result_d = 32'h0;
    unique case (req_i.op)
      packed_float_norm_convert_pkg::OP_DEC_UF11: begin
        result_d = dec11;
      end
      packed_float_norm_convert_pkg::OP_DEC_UF10: begin
        result_d = dec10;
      end
      packed_float_norm_convert_pkg::OP_ENC_UF11: begin
        result_d = 32'(enc11);
      end
      packed_float_norm_convert_pkg::OP_ENC_UF10: begin
        result_d = 32'(enc10);
      end
      packed_float_norm_convert_pkg::OP_FIX_TO_FLT: begin
        // signed 16.16: magnitude then scale by 2^-16
        mag      = sgn ? (~req_i.data + 32'h1) : req_i.data;
        result_d = mag_to_flt(sgn, mag, packed_float_norm_convert_pkg::FIX_FRAC_W);
      end
      packed_float_norm_convert_pkg::OP_UNORM_TO_FLT: begin
        // divisor is the constant 2^b-1, never zero
        if (cb == UMAX) begin
          result_d = packed_float_norm_convert_pkg::FLT_ONE;
        end else begin
          result_d = mag_to_flt(1'b0, rep_frac(cb, B),
                                packed_float_norm_convert_pkg::NORM_FRAC_W);
        end
      end
      packed_float_norm_convert_pkg::OP_SNORM_TO_FLT: begin
        sgn = cb[B-1];
        mag = sgn ? ((~cb + 32'h1) & BMASK) : cb;
        if (mag >= SMAX) begin
          // most negative code clamps like the next one up
          result_d = sgn ? packed_float_norm_convert_pkg::FLT_NEG_ONE
                         : packed_float_norm_convert_pkg::FLT_ONE;
        end else begin
          result_d = mag_to_flt(sgn, rep_frac(mag, B - 1),
                                packed_float_norm_convert_pkg::NORM_FRAC_W);
        end
      end
      packed_float_norm_convert_pkg::OP_FLT_TO_UNORM: begin
        if (is_nan || sgn) begin
          result_d = 32'h0;
        end else if (ge_one) begin
          result_d = UMAX;
        end else begin
          result_d = scale_norm(req_i.data, B) & BMASK;
        end
      end
      packed_float_norm_convert_pkg::OP_FLT_TO_SNORM: begin
        if (is_nan) begin
          mag = 32'h0;
        end else if (ge_one) begin
          mag = SMAX;
        end else begin
          mag = scale_norm(req_i.data, B - 1);
        end
        result_d = (sgn ? (~mag + 32'h1) : mag) & BMASK;
      end
      default: begin
        result_d = 32'h0;
      end
    endcase
  end

  // one result per accepted request, one cycle later, no stall state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_q <= 32'h0;
    end else if (valid_i) begin
      data_q <= result_d;
    end
  end

  assign rsp_o.valid = valid_q;
  assign rsp_o.data  = data_q;

  // assertions
  rsp_timing_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i |=> rsp_o.valid ##1 (rsp_o.valid == $past(valid_i)))
    else $error("response valid not one cycle after request");

  enc11_sat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF11 && !req_i.data[31]
      && req_i.data[30:23] > 8'h8e && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == 32'(packed_float_norm_convert_pkg::UF11_MAX_CODE))
    else $error("11-bit encode did not saturate to 65024");

  enc10_sat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF10 && !req_i.data[31]
      && req_i.data[30:23] > 8'h8e && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == 32'(packed_float_norm_convert_pkg::UF10_MAX_CODE))
    else $error("10-bit encode did not saturate to 64512");

  enc_special_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF11
      && req_i.data[30:23] == 8'hff
    |=> (rsp_o.data[10:6] == 5'h1f) ? ($past(req_i.data[31]) == 1'b0
          || $past(req_i.data[22:0]) != 23'h0) : ($past(req_i.data[31])
          && $past(req_i.data[22:0]) == 23'h0 && rsp_o.data == 32'h0))
    else $error("11-bit encode of inf or nan wrong");

  enc_negative_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF10 && req_i.data[31]
      && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == 32'h0)
    else $error("negative finite did not encode to zero");

  dec_inf_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_DEC_UF11
      && req_i.data[10:0] == packed_float_norm_convert_pkg::UF11_INF_CODE
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_POS_INF)
    else $error("11-bit infinity decoded wrong");

  dec10_norm_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_DEC_UF10
      && req_i.data[9:5] != 5'h00 && req_i.data[9:5] != 5'h1f
    |=> rsp_o.data[30:23] == 8'($past(req_i.data[9:5]) + 8'd112)
        && rsp_o.data[22:18] == $past(req_i.data[4:0]) && !rsp_o.data[31])
    else $error("10-bit normal decoded wrong");

  unorm_one_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_UNORM_TO_FLT
      && (req_i.data & BMASK) == UMAX
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_ONE)
    else $error("full-scale unorm not one");

  snorm_clamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_SNORM_TO_FLT
      && (req_i.data & BMASK) == (UMAX ^ SMAX)
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_NEG_ONE)
    else $error("most negative snorm not clamped to minus one");

  f2unorm_clamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_UNORM
      && !req_i.data[31] && req_i.data[30:23] >= 8'h7f && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == UMAX)
    else $error("float at or above one not clamped to unorm max");

  f2snorm_clamp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_SNORM
      && req_i.data[31] && req_i.data[30:23] >= 8'h7f && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == (((~SMAX) + 32'h1) & BMASK))
    else $error("float at or below minus one not clamped to snorm min");

  width_b_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && (req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_UNORM
      || req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_SNORM)
    |=> (rsp_o.data & ~BMASK) == 32'h0)
    else $error("normalized result wider than b bits");

  fix_sign_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FIX_TO_FLT
      && req_i.data == 32'h0001_0000
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_ONE)
    else $error("fixed 1.0 not converted to float one");

  rsp_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !valid_i
    |=> $stable(rsp_o.data))
    else $error("response data changed without a request");

  reset_idle_a: assert property (@(posedge clk_i)
    sys_rst_i
    |=> !rsp_o.valid && rsp_o.data == 32'h0)
    else $error("response not cleared by reset");

  dec11_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_DEC_UF11
      && req_i.data[10:0] == 11'h000
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_ZERO)
    else $error("11-bit zero decoded wrong");

  dec11_norm_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_DEC_UF11
      && req_i.data[10:6] != 5'h00 && req_i.data[10:6] != 5'h1f
    |=> rsp_o.data[30:23] == 8'($past(req_i.data[10:6]) + 8'd112)
        && rsp_o.data[22:17] == $past(req_i.data[5:0]))
    else $error("11-bit normal decoded wrong");

  dec10_nan_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_DEC_UF10
      && req_i.data[9:5] == 5'h1f && req_i.data[4:0] != 5'h00
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_QNAN)
    else $error("10-bit nan decoded wrong");

  enc_flush_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && (req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF11
      || req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF10)
      && req_i.data[30:23] == 8'h00
    |=> rsp_o.data == 32'h0)
    else $error("denormal input not flushed to zero");

  enc10_nan_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_ENC_UF10
      && req_i.data[30:23] == 8'hff && req_i.data[22:0] != 23'h0
    |=> rsp_o.data[9:5] == 5'h1f && rsp_o.data[4:0] != 5'h00)
    else $error("10-bit encode of nan not positive nan");

  fix_neg_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FIX_TO_FLT && req_i.data[31]
    |=> rsp_o.data[31])
    else $error("negative fixed value lost its sign");

  unorm_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_UNORM_TO_FLT
      && (req_i.data & BMASK) == 32'h0
    |=> rsp_o.data == packed_float_norm_convert_pkg::FLT_ZERO)
    else $error("zero unorm not converted to zero");

  f2unorm_neg_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_UNORM && req_i.data[31]
    |=> rsp_o.data == 32'h0)
    else $error("negative float not clamped to unorm zero");

  f2snorm_max_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op == packed_float_norm_convert_pkg::OP_FLT_TO_SNORM
      && !req_i.data[31] && req_i.data[30:23] >= 8'h7f && req_i.data[30:23] != 8'hff
    |=> rsp_o.data == SMAX)
    else $error("float at or above one not clamped to snorm max");

  illegal_op_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    valid_i && req_i.op > packed_float_norm_convert_pkg::OP_FLT_TO_SNORM
    |=> rsp_o.data == 32'h0)
    else $error("unused operation code gave nonzero data");

endmodule : packed_float_norm_convert

//--- packed_float_norm_convert_bench.sv
// self-checking testbench of the numeric conversion datapath
`timescale 1ns/1ns
module packed_float_norm_convert_bench;

  `define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end

  logic                                 clk_i = 1'b0;
  logic                                 sys_rst_i;
  logic                                 valid_i;
  packed_float_norm_convert_pkg::req_t  req_i;
  packed_float_norm_convert_pkg::rsp_t  rsp_o;
  logic [31:0]                          exp_q[$];
  logic [31:0]                          last_exp;
  logic                                 pend;
  logic                                 rst_seen;
  int                                   n_mismatch;
  int                                   comparisons;

  packed_float_norm_convert #(
    .B (8)
  ) packed_float_norm_convert_i (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .valid_i   (valid_i),
    .req_i     (req_i),
    .rsp_o     (rsp_o)
  );

  always #5 clk_i = ~clk_i;

  // response monitor: one pulse per taken request, data held between
  always @(posedge clk_i) begin
    pend     <= valid_i & ~sys_rst_i;
    rst_seen <= sys_rst_i;
  end

  always @(negedge clk_i) begin
    if (rst_seen) begin
      `CHK("valid in reset", 1'b0, rsp_o.valid)
      `CHK("data in reset", 32'h0000_0000, rsp_o.data)
      last_exp = 32'h0000_0000;
    end else if (pend) begin
      `CHK("valid after request", 1'b1, rsp_o.valid)
      if (exp_q.size() > 0) begin
        last_exp = exp_q.pop_front();
      end
      `CHK("result", last_exp, rsp_o.data)
    end else begin
      `CHK("valid idle", 1'b0, rsp_o.valid)
      `CHK("data held", last_exp, rsp_o.data)
    end
  end

  task automatic send(input packed_float_norm_convert_pkg::op_t op, input logic [31:0] d,
                      input logic [31:0] e);
    @(posedge clk_i);
    valid_i <= 1'b1;
    req_i   <= '{op: op, data: d};
    exp_q.push_back(e);
  endtask : send

  task automatic burst_end;
    @(posedge clk_i);
    valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("queue drained", 32'h0000_0000, 32'(exp_q.size()))
  endtask : burst_end

  task automatic t_dec11;
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'h0000_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'hffff_f3c0, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'h0000_0001, 32'h3580_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'h0000_07bf, 32'h477e_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'h0000_07c0, 32'h7f80_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF11, 32'h0000_07c1, 32'h7fc0_0000);
    burst_end();
  endtask : t_dec11

  task automatic t_dec10;
    send(packed_float_norm_convert_pkg::OP_DEC_UF10, 32'hffff_fde0, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF10, 32'h0000_0001, 32'h3600_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF10, 32'h0000_03df, 32'h477c_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF10, 32'h0000_03e0, 32'h7f80_0000);
    send(packed_float_norm_convert_pkg::OP_DEC_UF10, 32'h0000_03e1, 32'h7fc0_0000);
    burst_end();
  endtask : t_dec10

  task automatic t_enc11;
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h3f80_0000, 32'h0000_03c0);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h3f81_0000, 32'h0000_03c1);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h3f80_8000, 32'h0000_03c0);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'hbf80_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h477f_0000, 32'h0000_07bf);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h7f7f_ffff, 32'h0000_07bf);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'hff80_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h7f80_0000, 32'h0000_07c0);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'hffc0_0000, 32'h0000_07c1);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h0000_0001, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_ENC_UF11, 32'h3580_0000, 32'h0000_0001);
    burst_end();
  endtask : t_enc11

  task automatic t_enc10;
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h3f80_0000, 32'h0000_01e0);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h3f82_0000, 32'h0000_01e1);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'hc000_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h477c_0000, 32'h0000_03df);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h477f_0000, 32'h0000_03df);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h7f7f_ffff, 32'h0000_03df);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'hff80_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h7f80_0000, 32'h0000_03e0);
    send(packed_float_norm_convert_pkg::OP_ENC_UF10, 32'h7fc0_0000, 32'h0000_03e1);
    burst_end();
  endtask : t_enc10

  task automatic t_fix;
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'h0001_0000, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'hffff_0000, 32'hbf80_0000);
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'h0001_8000, 32'h3fc0_0000);
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'h0000_0001, 32'h3780_0000);
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'h8000_0000, 32'hc700_0000);
    send(packed_float_norm_convert_pkg::OP_FIX_TO_FLT, 32'h0000_0000, 32'h0000_0000);
    burst_end();
  endtask : t_fix

  task automatic t_norm_to_flt;
    send(packed_float_norm_convert_pkg::OP_UNORM_TO_FLT, 32'h0000_00ff, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_UNORM_TO_FLT, 32'h0000_0055, 32'h3eaa_aaaa);
    send(packed_float_norm_convert_pkg::OP_UNORM_TO_FLT, 32'hffff_ff00, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_UNORM_TO_FLT, 32'h0000_01ff, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_SNORM_TO_FLT, 32'h0000_007f, 32'h3f80_0000);
    send(packed_float_norm_convert_pkg::OP_SNORM_TO_FLT, 32'h0000_0081, 32'hbf80_0000);
    send(packed_float_norm_convert_pkg::OP_SNORM_TO_FLT, 32'h0000_0080, 32'hbf80_0000);
    send(packed_float_norm_convert_pkg::OP_SNORM_TO_FLT, 32'h0000_0100, 32'h0000_0000);
    burst_end();
  endtask : t_norm_to_flt

  task automatic t_flt_to_norm;
    send(packed_float_norm_convert_pkg::OP_FLT_TO_UNORM, 32'h3f80_0000, 32'h0000_00ff);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_UNORM, 32'h4000_0000, 32'h0000_00ff);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_UNORM, 32'hbf80_0000, 32'h0000_0000);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_UNORM, 32'h3f00_0000, 32'h0000_0080);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_SNORM, 32'h3f80_0000, 32'h0000_007f);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_SNORM, 32'hc000_0000, 32'h0000_0081);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_SNORM, 32'h3f00_0000, 32'h0000_0040);
    send(packed_float_norm_convert_pkg::OP_FLT_TO_SNORM, 32'hbf00_0000, 32'h0000_00c0);
    burst_end();
  endtask : t_flt_to_norm

  task automatic t_illegal_and_reset;
    send(packed_float_norm_convert_pkg::op_t'(4'h9), 32'h3f80_0000, 32'h0000_0000);
    @(posedge clk_i);
    req_i     <= '{op: packed_float_norm_convert_pkg::OP_ENC_UF11, data: 32'h3f80_0000};
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    valid_i <= 1'b0;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    valid_i   <= 1'b1;
    exp_q.push_back(32'h0000_03c0);
    burst_end();
  endtask : t_illegal_and_reset

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    sys_rst_i   = 1'b1;
    valid_i     = 1'b0;
    req_i       = '0;
    last_exp    = 32'h0000_0000;
    pend        = 1'b0;
    rst_seen    = 1'b0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_dec11();
    t_dec10();
    t_enc11();
    t_enc10();
    t_fix();
    t_norm_to_flt();
    t_flt_to_norm();
    t_illegal_and_reset();
    give_verdict();
  end

  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end

endmodule : packed_float_norm_convert_bench

//--- packed_float_norm_convert_pkg.sv
// shared constants, types and helpers of the numeric conversion datapath
package packed_float_norm_convert_pkg;

  localparam int          FLT_W         = 32;
  localparam int          FLT_MANT_W    = 23;
  localparam int          FLT_EXP_W     = 8;
  localparam int          FLT_EXP_BIAS  = 127;
  localparam int          FLT_EXP_SPEC  = 255;
  localparam logic [31:0] FLT_ZERO      = 32'h0000_0000;
  localparam logic [31:0] FLT_POS_INF   = 32'h7f80_0000;
  localparam logic [31:0] FLT_QNAN      = 32'h7fc0_0000;
  localparam logic [31:0] FLT_ONE       = 32'h3f80_0000;
  localparam logic [31:0] FLT_NEG_ONE   = 32'hbf80_0000;

  localparam int          PK_EXP_W      = 5;
  localparam int          PK_EXP_SPEC   = 31;
  localparam int          PK_EXP_TOP    = 30;
  localparam int          PK_EXP_BIAS   = 15;
  localparam int          PK_DEN_SHIFT  = 14;
  localparam int          UF11_MANT_W   = 6;
  localparam int          UF10_MANT_W   = 5;
  localparam int          UF11_W        = 11;
  localparam int          UF10_W        = 10;
  localparam logic [10:0] UF11_MAX_CODE = 11'h7bf;
  localparam logic [10:0] UF11_INF_CODE = 11'h7c0;
  localparam logic [9:0]  UF10_MAX_CODE = 10'h3df;
  localparam logic [9:0]  UF10_INF_CODE = 10'h3e0;

  localparam int          FIX_FRAC_W    = 16;
  localparam int          NORM_FRAC_W   = 32;
  localparam int          NORM_B_DEF    = 8;

  typedef enum logic [3:0] {
    OP_DEC_UF11,
    OP_DEC_UF10,
    OP_ENC_UF11,
    OP_ENC_UF10,
    OP_FIX_TO_FLT,
    OP_UNORM_TO_FLT,
    OP_SNORM_TO_FLT,
    OP_FLT_TO_UNORM,
    OP_FLT_TO_SNORM
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [31:0] data;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } rsp_t;

  // position of the highest set bit, zero for zero
  function automatic logic [4:0] lead_one(input logic [31:0] v);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    return p;
  endfunction : lead_one

endpackage : packed_float_norm_convert_pkg
